//--- dio_irq_cfg_regs.vh
// register offsets, field positions and reset values of the digital line
// interrupt and global configuration bank
// assumes a 32-bit aligned-word register bus
`ifndef DIO_IRQ_CFG_REGS_VH
`define DIO_IRQ_CFG_REGS_VH

`define OFS_EDGE_FLAGS     12'h38c
`define OFS_GLOBAL_CFG     12'h398
`define OFS_FRONT_PULL     12'h39c
`define OFS_AUX_PULL       12'h3a0
`define OFS_RISE_ENABLE    12'h3b0
`define OFS_FALL_ENABLE    12'h3b4
`define OFS_IRQ_ENABLE     12'h3b8
`define OFS_IRQ_CLEAR      12'h3bc

`define ADDR_MSB           11
`define LINE_COUNT         8
`define FIELD_FLAGS_MSB    7
`define FIELD_PULL_MSB     1
`define CFG_ENDIAN_BIT     0
`define CFG_ACK_MODE_BIT   1
`define ACK_CLEAR_BY_WRITE 1'h0
`define ACK_CLEAR_ON_READ  1'h1
`define ENDIAN_LITTLE      1'h0
`define PULL_FLOATING      2'h0
`define PULL_UP_5V         2'h1
`define PULL_UP_3V3        2'h2
`define PULL_DOWN_GND      2'h3
`define RST_FLAGS          8'h00
`define RST_PULL           2'h0
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

//--- dio_irq_props.sv
// assertion checker for the edge flag and configuration bank
// assumes it is bound into the bank and sees only the bank's ports
`timescale 1ns/1ps
`default_nettype none
module dio_irq_props (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // bus handshakes and read data
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   // interrupt and sample steering
   input wire logic        irq,
   input wire logic [15:0] sample_in,
   input wire logic [15:0] sample_to_host,
   input wire logic        dma_byte_swap,
   // pull reference controls
   input wire logic        front_ref_5v,
   input wire logic        front_ref_3v3,
   input wire logic        front_ref_gnd,
   input wire logic        aux_ref_5v,
   input wire logic        aux_ref_3v3,
   input wire logic        aux_ref_gnd
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // a read accepted, then its answer one cycle on
   sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
   sequence answered; ##1 s_axi_rvalid; endsequence
   // both selector groups as one vector, changes only near a write answer
   wire [5:0] refs = {front_ref_5v, front_ref_3v3, front_ref_gnd,
                      aux_ref_5v, aux_ref_3v3, aux_ref_gnd};
   a_pass_order: assert property ($past(aresetn) && !dma_byte_swap
      |-> sample_to_host == $past(sample_in))
      else $error("sample changed order without swap");
   a_swap_bytes: assert property ($past(aresetn) && dma_byte_swap
      |-> sample_to_host == {$past(sample_in[7:0]),
      $past(sample_in[15:8])})
      else $error("sample bytes not swapped");
   a_front_onehot: assert property ($onehot0(refs[5:3]))
      else $error("front reference drives two levels");
   a_aux_onehot: assert property ($onehot0(refs[2:0]))
      else $error("aux reference drives two levels");
   a_reset_float: assert property ($rose(aresetn)
      |-> refs == 6'h0 && !dma_byte_swap)
      else $error("selectors not cleared by reset");
   a_ref_write: assert property (!$stable(refs)
      |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("reference moved without a write");
   a_swap_write: assert property ($changed(dma_byte_swap)
      |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("byte order moved without a write");
   a_irq_fall: assert property ($fell(irq) |-> s_axi_bvalid
      || $past(s_axi_bvalid) || s_axi_rvalid || $past(s_axi_rvalid))
      else $error("interrupt dropped with no bus access");
   a_resv_zero: assert property (ar_taken ##0 answered
      |-> s_axi_rdata[31:8] == 24'h0)
      else $error("reserved read bits not zero");
endmodule
bind dio_irq_status_and_global_config dio_irq_props u_props (.*);
`default_nettype wire

//--- dio_irq_status_and_global_config.v
// register bank: per-line edge flags, acknowledge mode, dma byte order,
// pull reference selectors, with an axi4-lite slave
// assumes one 200 MHz clock aclk; digital lines are asynchronous pins
// Function
// - one flag per front line, bits 7:0, set by enabled rising/falling edges.
// - global config bit 1 selects clear-by-write (0) or clear-on-read (1).
// - clear-by-write: writing one clears that flag; zero leaves it.
// - clear-on-read: a read clears flags only in byte lanes enabled.
// - global config bit 0 is the shared sequencer dma byte-order selector.
// - 16-bit samples go to host memory little-endian in default order.
// - both pull selectors reset to 00, reference floating.
// - aux selector bits 1:0 sets reference for conversion clocks and trigger.
// - each selector drives one reference node common to its group.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "dio_irq_cfg_regs.vh"

module dio_irq_status_and_global_config (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite write address and data
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read; arprot unused, read byte lanes come from s_axi_arstrb
   input  wire [11:0] s_axi_araddr,
   input  wire [3:0]  s_axi_arstrb,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // front digital lines, asynchronous
   input  wire [7:0]  front_line_in,
   // interrupt
   output reg         irq,
   // sequencer dma sample byte steering
   input  wire [15:0] sample_in,
   output reg  [15:0] sample_to_host,
   output reg         dma_byte_swap,
   // pull reference controls, one-hot per group, all low means floating
   output reg         front_ref_5v,
   output reg         front_ref_3v3,
   output reg         front_ref_gnd,
   output reg         aux_ref_5v,
   output reg         aux_ref_3v3,
   output reg         aux_ref_gnd
);

   reg  [7:0]  line_sync1;
   reg  [7:0]  line_sync2;
   reg  [7:0]  line_prev;
   reg  [7:0]  rise_enable;
   reg  [7:0]  fall_enable;
   reg  [7:0]  irq_enable;
   reg  [7:0]  edge_flags;
   reg         ack_mode;
   reg         byte_order;
   reg  [1:0]  front_line_pull_select;
   reg  [1:0]  aux_line_pull_select;
   reg  [11:0] wr_addr;
   reg  [31:0] wr_data;
   reg  [3:0]  wr_strb;
   reg         wr_addr_held;
   reg         wr_data_held;
   reg  [7:0]  next_edge_flags;
   reg  [7:0]  edge_events;
   reg  [7:0]  clear_mask;
   reg  [31:0] rd_word;
   reg         rd_hit;
   reg         wr_hit;
   wire        wr_go;
   wire        rd_go;
   wire        wr_clears;
   wire        rd_clears;

   // two-stage synchroniser, then a history stage for edge detection
   // only the second stage reads the first, so no metastable value leaks
   always @(posedge aclk) begin
      if (!aresetn) begin
         line_sync1 <= 8'h00;
         line_sync2 <= 8'h00;
         line_prev  <= 8'h00;
      end else begin
         line_sync1 <= front_line_in;
         line_sync2 <= line_sync1;
         line_prev  <= line_sync2;
      end
   end

   // write fires once both address and data are held and no response pends
   assign wr_go = wr_addr_held && wr_data_held && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;

   // address and data latch independently, in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'h1;
         s_axi_wready  <= 1'h1;
         wr_addr_held  <= 1'h0;
         wr_data_held  <= 1'h0;
         wr_addr       <= 12'h000;
         wr_data       <= 32'h00000000;
         wr_strb       <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            wr_addr       <= s_axi_awaddr;
            wr_addr_held  <= 1'h1;
            s_axi_awready <= 1'h0;
         end else if (wr_go) begin
            wr_addr_held  <= 1'h0;
            s_axi_awready <= 1'h1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wr_data      <= s_axi_wdata;
            wr_strb      <= s_axi_wstrb;
            wr_data_held <= 1'h1;
            s_axi_wready <= 1'h0;
         end else if (wr_go) begin
            wr_data_held <= 1'h0;
            s_axi_wready <= 1'h1;
         end
      end
   end

   // write decode; unmapped offsets answer slverr and change nothing
   // the decode sees the held address, so aw may land before w
   always @* begin
      case (wr_addr)
         `OFS_EDGE_FLAGS, `OFS_GLOBAL_CFG, `OFS_FRONT_PULL, `OFS_AUX_PULL,
         `OFS_RISE_ENABLE, `OFS_FALL_ENABLE, `OFS_IRQ_ENABLE,
         `OFS_IRQ_CLEAR: wr_hit = 1'h1;
         default: wr_hit = 1'h0;
      endcase
   end

   // write response, one cycle after the write fires
   // a held response blocks the next store, keeping one write in flight
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'h0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'h1;
         s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'h0;
      end
   end

   // control registers; only low-lane bits exist, the rest are dropped
   always @(posedge aclk) begin
      if (!aresetn) begin
         ack_mode               <= `ACK_CLEAR_BY_WRITE;
         byte_order             <= `ENDIAN_LITTLE;
         front_line_pull_select <= `RST_PULL;
         aux_line_pull_select   <= `RST_PULL;
         rise_enable            <= `RST_FLAGS;
         fall_enable            <= `RST_FLAGS;
         irq_enable             <= `RST_FLAGS;
      end else if (wr_go && wr_strb[0]) begin
         case (wr_addr)
            `OFS_GLOBAL_CFG: begin
               ack_mode   <= wr_data[`CFG_ACK_MODE_BIT];
               byte_order <= wr_data[`CFG_ENDIAN_BIT];
            end
            `OFS_FRONT_PULL:
               front_line_pull_select <= wr_data[`FIELD_PULL_MSB:0];
            `OFS_AUX_PULL:
               aux_line_pull_select <= wr_data[`FIELD_PULL_MSB:0];
            `OFS_RISE_ENABLE: rise_enable <= wr_data[`FIELD_FLAGS_MSB:0];
            `OFS_FALL_ENABLE: fall_enable <= wr_data[`FIELD_FLAGS_MSB:0];
            `OFS_IRQ_ENABLE:  irq_enable  <= wr_data[`FIELD_FLAGS_MSB:0];
            default: ;
         endcase
      end
   end

   // acknowledge paths: a clear-by-write store, or a read accepted in
   // clear-on-read mode with lane 0 enabled; only lane 0 holds flags
   assign wr_clears = wr_go && wr_strb[0] &&
                      ack_mode == `ACK_CLEAR_BY_WRITE &&
                      (wr_addr == `OFS_EDGE_FLAGS ||
                       wr_addr == `OFS_IRQ_CLEAR);
   assign rd_clears = rd_go && ack_mode == `ACK_CLEAR_ON_READ &&
                      s_axi_araddr == `OFS_EDGE_FLAGS &&
                      s_axi_arstrb[0];

   // flag update: edge events set, acknowledges clear; a set wins the tie
   // so an edge landing on the acknowledge cycle is never lost
   always @* begin
      edge_events = (line_sync2 & ~line_prev & rise_enable) |
                    (~line_sync2 & line_prev & fall_enable);
      clear_mask = 8'h00;
      if (wr_clears)
         clear_mask = wr_data[`FIELD_FLAGS_MSB:0];
      if (rd_clears)
         clear_mask = clear_mask | edge_flags;
      next_edge_flags = (edge_flags & ~clear_mask) | edge_events;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         edge_flags <= `RST_FLAGS;
      end else begin
         edge_flags <= next_edge_flags;
      end
   end

   // read mux; reserved bits are zero
   always @* begin
      rd_word = 32'h00000000;
      rd_hit  = 1'h1;
      case (s_axi_araddr)
         `OFS_EDGE_FLAGS:  rd_word[`FIELD_FLAGS_MSB:0] = edge_flags;
         `OFS_GLOBAL_CFG: begin
            rd_word[`CFG_ACK_MODE_BIT] = ack_mode;
            rd_word[`CFG_ENDIAN_BIT]   = byte_order;
         end
         `OFS_FRONT_PULL:  rd_word[`FIELD_PULL_MSB:0] = front_line_pull_select;
         `OFS_AUX_PULL:    rd_word[`FIELD_PULL_MSB:0] = aux_line_pull_select;
         `OFS_RISE_ENABLE: rd_word[`FIELD_FLAGS_MSB:0] = rise_enable;
         `OFS_FALL_ENABLE: rd_word[`FIELD_FLAGS_MSB:0] = fall_enable;
         `OFS_IRQ_ENABLE:  rd_word[`FIELD_FLAGS_MSB:0] = irq_enable;
         `OFS_IRQ_CLEAR:   rd_word = 32'h00000000; // write-only
         default:          rd_hit = 1'h0;
      endcase
   end

   // read channel: one read in flight, data registered on acceptance
   // arready stays low until the answer is taken, so rdata cannot move
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'h1;
         s_axi_rvalid  <= 1'h0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (rd_go) begin
         s_axi_arready <= 1'h0;
         s_axi_rvalid  <= 1'h1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'h0;
         s_axi_arready <= 1'h1;
      end
   end

   // interrupt level, one cycle behind the flags so it leaves a flip-flop
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'h0;
      end else begin
         irq <= |(edge_flags & irq_enable);
      end
   end

   // dma byte steering; flag and sample load on one edge, so a watcher
   // can pair them without tracking the configuration write
   always @(posedge aclk) begin
      if (!aresetn) begin
         dma_byte_swap  <= 1'h0;
         sample_to_host <= 16'h0000;
      end else begin
         dma_byte_swap <= byte_order;
         // little-endian keeps low byte first; swap reverses the pair
         sample_to_host <= (byte_order == `ENDIAN_LITTLE) ? sample_in :
                           {sample_in[7:0], sample_in[15:8]};
      end
   end

   // pull decode: one node per group; floating leaves every switch open
   always @(posedge aclk) begin
      if (!aresetn) begin
         front_ref_5v  <= 1'h0;
         front_ref_3v3 <= 1'h0;
         front_ref_gnd <= 1'h0;
         aux_ref_5v    <= 1'h0;
         aux_ref_3v3   <= 1'h0;
         aux_ref_gnd   <= 1'h0;
      end else begin
         front_ref_5v  <= front_line_pull_select == `PULL_UP_5V;
         front_ref_3v3 <= front_line_pull_select == `PULL_UP_3V3;
         front_ref_gnd <= front_line_pull_select == `PULL_DOWN_GND;
         aux_ref_5v    <= aux_line_pull_select == `PULL_UP_5V;
         aux_ref_3v3   <= aux_line_pull_select == `PULL_UP_3V3;
         aux_ref_gnd   <= aux_line_pull_select == `PULL_DOWN_GND;
      end
   end

endmodule

`default_nettype wire

//--- dio_irq_status_and_global_config_tb.sv
// self-checking bench for the edge flag and configuration bank
// assumes the bank, its header and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "dio_irq_cfg_regs.vh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
   n_fail++; $display("Error %s expected %h seen %h", nm, ex, gt); end end
module dio_irq_status_and_global_config_tb;
   logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0;
   logic        arv = 0, rready = 0, awr, wr_rdy, bv, arr, rv, irq, swp;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [3:0]  arstrb = 4'hf;
   logic [1:0]  bresp, rresp, rs;
   logic [7:0]  lines = 8'h00;
   logic [15:0] smp = 16'h12a5, smp_out, sm;
   logic [2:0]  fref, aref;
   int          n_fail = 0, compares = 0, i;

   dio_irq_status_and_global_config dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arstrb(arstrb),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
      .front_line_in(lines), .irq(irq), .sample_in(smp),
      .sample_to_host(smp_out), .dma_byte_swap(swp),
      .front_ref_5v(fref[0]), .front_ref_3v3(fref[1]),
      .front_ref_gnd(fref[2]), .aux_ref_5v(aref[0]),
      .aux_ref_3v3(aref[1]), .aux_ref_gnd(aref[2]));

   // clock, and a sample stream that keeps both bytes moving
   always #2.5 aclk = ~aclk;
   always @(posedge aclk) smp <= smp + 16'h0103;

   // expected one-hot {gnd, 3v3, 5v} for a selector code
   function automatic [2:0] code(input int c);
      code = (c == 0) ? 3'b000 : 3'b001 << (c - 1);
   endfunction

   // write: address and data offered together, released as each is taken
   task automatic wr(input [11:0] a, input [31:0] v);
      @(posedge aclk);
      awaddr <= a; wdata <= v; awv <= 1; wv <= 1; bready <= 1;
      fork
         begin do @(posedge aclk); while (!awr); awv <= 0; end
         begin do @(posedge aclk); while (!wr_rdy); wv <= 0; end
      join
      while (!bv) @(posedge aclk);
      rs = bresp;
      bready <= 0;
   endtask

   // read with chosen byte lanes, then compare the data
   task automatic rc(input [11:0] a, input [3:0] s, input [31:0] e);
      @(posedge aclk);
      araddr <= a; arstrb <= s; arv <= 1; rready <= 1;
      do @(posedge aclk); while (!arr);
      arv <= 0;
      do @(posedge aclk); while (!rv);
      d = rdata;
      rs = rresp;
      rready <= 0;
      `CHK("rdata", e, d)
   endtask

   task automatic wrap_up;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // a run of about 150 cycles; far longer means a stuck handshake
   initial begin
      repeat (5000) @(posedge aclk);
      n_fail++;
      $display("Error watchdog expected done seen hang");
      wrap_up;
   end

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      rc(`OFS_EDGE_FLAGS, 4'hf, 0);
      rc(`OFS_GLOBAL_CFG, 4'hf, 0);
      rc(`OFS_FRONT_PULL, 4'hf, 0);
      rc(`OFS_AUX_PULL, 4'hf, 0);
      // every selector code in both groups, reserved bits set on the front writes
      for (i = 0; i < 4; i++) begin
         wr(`OFS_FRONT_PULL, 32'hfffffffc | i);
         wr(`OFS_AUX_PULL, 3 - i);
         rc(`OFS_FRONT_PULL, 4'hf, i);
         `CHK("front ref", code(i), fref)
         `CHK("aux ref", code(3 - i), aref)
      end
      wr(`OFS_GLOBAL_CFG, 32'hffffffff);
      rc(`OFS_GLOBAL_CFG, 4'hf, 32'h3);
      `CHK("byte swap", 1'b1, swp)
      // the stream steps each edge; the output holds last edge's sample
      sm = smp - 16'h0103;
      sm = {sm[7:0], sm[15:8]};
      `CHK("swapped sample", sm, smp_out)
      wr(`OFS_GLOBAL_CFG, 0);
      // rising edges on lines 1 and 8, clear-by-write
      wr(`OFS_RISE_ENABLE, 32'hff);
      sm = smp - 16'h0103;
      `CHK("plain sample", sm, smp_out)
      wr(`OFS_FALL_ENABLE, 0);
      wr(`OFS_IRQ_ENABLE, 32'hff);
      lines <= 8'h81;
      repeat (8) @(posedge aclk);
      #1 `CHK("irq", 1'b1, irq)
      rc(`OFS_EDGE_FLAGS, 4'hf, 32'h81);
      wr(`OFS_EDGE_FLAGS, 32'h01);
      rc(`OFS_EDGE_FLAGS, 4'hf, 32'h80);
      wr(`OFS_IRQ_CLEAR, 32'h80);
      rc(`OFS_EDGE_FLAGS, 4'hf, 0);
      `CHK("irq", 1'b0, irq)
      // falling edges, only line 1 enabled; interrupt masked
      wr(`OFS_RISE_ENABLE, 0);
      wr(`OFS_FALL_ENABLE, 32'h01);
      wr(`OFS_IRQ_ENABLE, 0);
      lines <= 8'h00;
      repeat (8) @(posedge aclk);
      #1 `CHK("irq", 1'b0, irq)
      rc(`OFS_EDGE_FLAGS, 4'hf, 32'h01);
      // clear-on-read: writes ignored, only enabled byte lanes cleared
      wr(`OFS_GLOBAL_CFG, 32'h2);
      wr(`OFS_EDGE_FLAGS, 32'hff);
      rc(`OFS_EDGE_FLAGS, 4'he, 32'h01);
      rc(`OFS_EDGE_FLAGS, 4'hf, 32'h01);
      rc(`OFS_EDGE_FLAGS, 4'hf, 0);
      // unmapped address both ways
      wr(12'h3c0, 32'h1);
      `CHK("bresp", `RESP_SLVERR, rs)
      rc(12'h3c0, 4'hf, 0);
      `CHK("rresp", `RESP_SLVERR, rs)
      wrap_up;
   end
endmodule
`default_nettype wire
